// ==== rtl/vectored_interrupt_controller.sv ====
// Vectored interrupt controller with Avalon-MM register access
//
// What this block does
// R1: Thirteen pin requests, twenty-four peripheral requests
// R2: Only highest-priority pending request serviced
// R3: Global mask blocks acceptance, flags still set
// R4: Each pin selectable rising or falling edge
// R5: Lower vector wins; wakeups share vector 9
// R6: Timer C overflow and underflow use vector 13
// R7: Eight-bit timers share vectors 14 and 15
// R8: Capture timer events share vector 16
// R9: Serial channel events share vectors 17, 18
// R10: Reserved vector locations never dispatched
// R11: Flags clear by writing zero only
// R12: Edge select top bits read one
// R13: Edge bit 4 serves pin 4 and trigger
// R14: Enable registers reset to zero
// R15: Other registers reset to documented values
// R16: Edge bits 0-3 serve pins, timer pins
// R17: Enable bits 4-0 gate pin requests
// R18: Exception starts only at instruction boundary
// R19: Signal only when flagged, enabled, unmasked; serial levels need only be unmasked
// R20: Flags set regardless of enable bit
`timescale 1ns/100ps

module vectored_interrupt_controller
    import vic_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic [15:0]    avs_address,
    input  wire logic           avs_read,
    input  wire logic           avs_write,
    input  wire logic [31:0]    avs_writedata,
    input  wire logic [3:0]     avs_byteenable,
    output logic [31:0]         avs_readdata,
    output logic                avs_waitrequest,
    input  wire logic [4:0]     ext_request_pin,
    input  wire logic [7:0]     wake_pin,
    input  wire logic           conversion_trigger_pin,
    input  wire logic           timer_c_event_pin,
    input  wire logic           timer_f_event_pin,
    input  wire periph_events_t periph_events,
    input  wire logic           sleep_direct_event,
    input  wire logic           condition_code_mask,
    input  wire logic           instr_boundary,
    output core_request_t       core_request,
    output logic                exception_start,
    output logic                conversion_trigger_edge,
    output logic                timer_c_edge,
    output logic                timer_f_edge
);

    // =========================================================
    // Helper functions
    function automatic logic edge_seen(input logic now_v, input logic old_v,
                                       input logic rising);
        edge_seen = rising ? (now_v & ~old_v) : (~now_v & old_v);
    endfunction

    function automatic logic [4:0] first_set(input logic [31:0] req);
        first_set = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (req[i]) begin
                first_set = 5'(i);
            end
        end
    endfunction

    // =========================================================
    // Registers
    logic [7:0]  wake_edge_select_q;
    logic [4:0]  request_edge_select_q;
    logic [7:0]  source_enable_first_q;
    logic [7:0]  source_enable_second_q;
    logic [7:0]  request_flags_first_q;
    logic [7:0]  request_flags_first_d;
    logic [7:0]  request_flags_second_q;
    logic [7:0]  request_flags_second_d;
    logic [7:0]  wakeup_request_flags_q;
    logic [7:0]  wakeup_request_flags_d;
    logic        ack_q;
    logic [31:0] readdata_q;
    logic        wr_en;
    logic        rd_en;

    // =========================================================
    // Pin synchronisers and edge history
    logic [15:0] pin_meta_q;
    logic [15:0] pin_sync_q;
    logic [15:0] pin_old_q;
    logic [15:0] pin_now;
    logic [4:0]  pin_edges;
    logic [7:0]  wake_edges;

    assign pin_now = {timer_f_event_pin, timer_c_event_pin, conversion_trigger_pin,
                      wake_pin, ext_request_pin};

    // R1: pin capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 16'h0000;
            pin_sync_q <= 16'h0000;
            pin_old_q  <= 16'h0000;
        end else begin
            pin_meta_q <= pin_now;
            pin_sync_q <= pin_meta_q;
            pin_old_q  <= pin_sync_q;
        end
    end

    // R4: per pin edge choice
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_edges[i] = edge_seen(pin_sync_q[i], pin_old_q[i],
                                     request_edge_select_q[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wake_edges[i] = edge_seen(pin_sync_q[5 + i], pin_old_q[5 + i],
                                      wake_edge_select_q[i]);
        end
    end

    // R13: trigger pin follows bit 4
    // R16: timer pins follow bits 3 and 1
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_trigger_edge <= 1'b0;
            timer_c_edge            <= 1'b0;
            timer_f_edge            <= 1'b0;
        end else begin
            conversion_trigger_edge <= edge_seen(pin_sync_q[13], pin_old_q[13],
                                                 request_edge_select_q[4]);
            timer_c_edge <= edge_seen(pin_sync_q[14], pin_old_q[14],
                                      request_edge_select_q[1]);
            timer_f_edge <= edge_seen(pin_sync_q[15], pin_old_q[15],
                                      request_edge_select_q[3]);
        end
    end

    // =========================================================
    // Avalon-MM slave, one wait cycle per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_en           = avs_write & ack_q & avs_byteenable[0];
    assign rd_en           = avs_read & ~ack_q;
    assign avs_readdata    = readdata_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // R12: fixed ones in edge select
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata_q <= 32'h00000000;
        end else if (rd_en) begin
            case (avs_address)
                WAKE_EDGE_IDX:  readdata_q <= {24'h000000, wake_edge_select_q};
                REQ_EDGE_IDX:   readdata_q <= {24'h000000, EDGE_FIXED_ONES[7:5],
                                               request_edge_select_q};
                ENABLE_1_IDX:   readdata_q <= {24'h000000, source_enable_first_q};
                ENABLE_2_IDX:   readdata_q <= {24'h000000, source_enable_second_q};
                FLAGS_1_IDX:    readdata_q <= {24'h000000, request_flags_first_q};
                FLAGS_2_IDX:    readdata_q <= {24'h000000, request_flags_second_q};
                WAKE_FLAGS_IDX: readdata_q <= {24'h000000, wakeup_request_flags_q};
                default:        readdata_q <= 32'h00000000;
            endcase
        end
    end

    // =========================================================
    // Configuration registers
    // R14: enables start cleared
    // R15: edge selects reset values
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_edge_select_q     <= WAKE_EDGE_RST;
            request_edge_select_q  <= REQ_EDGE_RST[4:0];
            source_enable_first_q  <= ENABLE_RST;
            source_enable_second_q <= ENABLE_RST;
        end else if (wr_en) begin
            case (avs_address)
                WAKE_EDGE_IDX: wake_edge_select_q     <= avs_writedata[7:0];
                REQ_EDGE_IDX:  request_edge_select_q  <= avs_writedata[4:0];
                ENABLE_1_IDX:  source_enable_first_q  <= avs_writedata[7:0];
                ENABLE_2_IDX:  source_enable_second_q <= avs_writedata[7:0];
                default:       ;
            endcase
        end
    end

    // =========================================================
    // Request flags
    logic [7:0] set_first;
    logic [7:0] set_second;
    logic [7:0] keep_first;
    logic [7:0] keep_second;
    logic [7:0] keep_wake;

    // R20: flags set whatever the enables
    // R6: timer C pair feeds one flag
    // R7: compare and overflow share flag
    // R8: capture and overflow share flag
    always_comb begin
        set_first             = 8'h00;
        set_first[4:0]        = pin_edges;
        set_first[F1_WAKE]    = |wake_edges;
        set_first[F1_SYNC]    = periph_events.sync_serial_done;
        set_first[F1_TIMER_A] = periph_events.timer_a_ovf;
        set_second               = 8'h00;
        set_second[F2_ASYNC_CTR] = periph_events.async_ctr_ovf;
        set_second[F2_TIMER_C]   = periph_events.timer_c_ovf | periph_events.timer_c_udf;
        set_second[F2_TIMER_FL]  = periph_events.timer_fl_cmp | periph_events.timer_fl_ovf;
        set_second[F2_TIMER_FH]  = periph_events.timer_fh_cmp | periph_events.timer_fh_ovf;
        set_second[F2_TIMER_G]   = periph_events.timer_g_cap | periph_events.timer_g_ovf;
        set_second[F2_ADC]       = periph_events.adc_done;
        set_second[F2_DIRECT]    = sleep_direct_event;
    end

    // R11: write zero clears, one keeps
    always_comb begin
        keep_first  = 8'hff;
        keep_second = 8'hff;
        keep_wake   = 8'hff;
        if (wr_en) begin
            case (avs_address)
                FLAGS_1_IDX:    keep_first  = avs_writedata[7:0];
                FLAGS_2_IDX:    keep_second = avs_writedata[7:0];
                WAKE_FLAGS_IDX: keep_wake   = avs_writedata[7:0];
                default:        ;
            endcase
        end
        request_flags_first_d  = (request_flags_first_q & keep_first) | set_first;
        request_flags_second_d = (request_flags_second_q & keep_second) | set_second;
        wakeup_request_flags_d = (wakeup_request_flags_q & keep_wake) | wake_edges;
    end

    // R15: flag reset values
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            request_flags_first_q  <= FLAGS_1_RST;
            request_flags_second_q <= FLAGS_2_RST;
            wakeup_request_flags_q <= WAKE_FLAGS_RST;
        end else begin
            request_flags_first_q  <= request_flags_first_d;
            request_flags_second_q <= request_flags_second_d;
            wakeup_request_flags_q <= wakeup_request_flags_d;
        end
    end

    // =========================================================
    // Priority selection
    logic [31:0] vec_req;
    logic [4:0]  winner;
    logic        any_req;

    // R19: flag and enable both needed, except serial levels taken directly
    // R17: enable bits gate pin requests
    // R9: six serial events per vector
    always_comb begin
        vec_req = 32'h00000000;
        for (int i = 0; i < 5; i++) begin
            vec_req[VEC_PIN0 + 5'(i)] = request_flags_first_q[i] & source_enable_first_q[i];
        end
        vec_req[VEC_WAKE]    = request_flags_first_q[F1_WAKE] & source_enable_first_q[F1_WAKE];
        vec_req[VEC_SYNC]    = request_flags_first_q[F1_SYNC] & source_enable_first_q[F1_SYNC];
        vec_req[VEC_TIMER_A] = request_flags_first_q[F1_TIMER_A]
                               & source_enable_first_q[F1_TIMER_A];
        vec_req[VEC_ASYNC]   = request_flags_second_q[F2_ASYNC_CTR]
                               & source_enable_second_q[F2_ASYNC_CTR];
        vec_req[VEC_TIMER_C] = request_flags_second_q[F2_TIMER_C]
                               & source_enable_second_q[F2_TIMER_C];
        vec_req[VEC_FL]      = request_flags_second_q[F2_TIMER_FL]
                               & source_enable_second_q[F2_TIMER_FL];
        vec_req[VEC_FH]      = request_flags_second_q[F2_TIMER_FH]
                               & source_enable_second_q[F2_TIMER_FH];
        vec_req[VEC_G]       = request_flags_second_q[F2_TIMER_G]
                               & source_enable_second_q[F2_TIMER_G];
        vec_req[VEC_SER1]    = |periph_events.serial1_req;
        vec_req[VEC_SER2]    = |periph_events.serial2_req;
        vec_req[VEC_ADC]     = request_flags_second_q[F2_ADC]
                               & source_enable_second_q[F2_ADC];
        vec_req[VEC_DIRECT]  = request_flags_second_q[F2_DIRECT]
                               & source_enable_second_q[F2_DIRECT];
        // R10: reserved vectors removed
        vec_req = vec_req & ~VEC_RESERVED;
    end

    // R2: lowest vector number wins
    // R5: priority falls with vector
    assign winner  = first_set(vec_req);
    assign any_req = |vec_req;

    // R3: global mask holds off
    // R18: start only at boundary
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_request    <= '0;
            exception_start <= 1'b0;
        end else begin
            core_request.pending <= any_req & ~condition_code_mask;
            core_request.vector  <= winner;
            core_request.address <= {10'h000, winner, 1'b0};
            exception_start      <= any_req & ~condition_code_mask & instr_boundary;
        end
    end

endmodule

// ==== rtl/vic_pkg.sv ====
// Constants and types of the vectored interrupt controller
package vic_pkg;

    // =========================================================
    // Register word indices (byte address is four times these)
    localparam logic [15:0] WAKE_EDGE_IDX  = 16'hff90;
    localparam logic [15:0] REQ_EDGE_IDX   = 16'hfff2;
    localparam logic [15:0] ENABLE_1_IDX   = 16'hfff3;
    localparam logic [15:0] ENABLE_2_IDX   = 16'hfff4;
    localparam logic [15:0] FLAGS_1_IDX    = 16'hfff6;
    localparam logic [15:0] FLAGS_2_IDX    = 16'hfff7;
    localparam logic [15:0] WAKE_FLAGS_IDX = 16'hfff9;

    // =========================================================
    // Reset values
    localparam logic [7:0] WAKE_EDGE_RST  = 8'h00;
    localparam logic [7:0] REQ_EDGE_RST   = 8'he0;
    localparam logic [7:0] ENABLE_RST     = 8'h00;
    localparam logic [7:0] FLAGS_1_RST    = 8'h20;
    localparam logic [7:0] FLAGS_2_RST    = 8'h00;
    localparam logic [7:0] WAKE_FLAGS_RST = 8'h00;

    // =========================================================
    // Field positions
    localparam int EDGE_FIXED_MASK_POS = 5;
    localparam logic [7:0] EDGE_FIXED_ONES = 8'he0;
    localparam int F1_WAKE    = 5;
    localparam int F1_SYNC    = 6;
    localparam int F1_TIMER_A = 7;
    localparam int F2_ASYNC_CTR = 0;
    localparam int F2_TIMER_C   = 1;
    localparam int F2_TIMER_FL  = 2;
    localparam int F2_TIMER_FH  = 3;
    localparam int F2_TIMER_G   = 4;
    localparam int F2_ADC       = 6;
    localparam int F2_DIRECT    = 7;

    // =========================================================
    // Vector numbers
    localparam logic [4:0] VEC_PIN0    = 5'h04;
    localparam logic [4:0] VEC_WAKE    = 5'h09;
    localparam logic [4:0] VEC_SYNC    = 5'h0a;
    localparam logic [4:0] VEC_TIMER_A = 5'h0b;
    localparam logic [4:0] VEC_ASYNC   = 5'h0c;
    localparam logic [4:0] VEC_TIMER_C = 5'h0d;
    localparam logic [4:0] VEC_FL      = 5'h0e;
    localparam logic [4:0] VEC_FH      = 5'h0f;
    localparam logic [4:0] VEC_G       = 5'h10;
    localparam logic [4:0] VEC_SER1    = 5'h11;
    localparam logic [4:0] VEC_SER2    = 5'h12;
    localparam logic [4:0] VEC_ADC     = 5'h13;
    localparam logic [4:0] VEC_DIRECT  = 5'h14;
    // Vectors 0 to 3 and 10 never dispatch
    localparam logic [31:0] VEC_RESERVED = 32'h0000040f;

    // =========================================================
    // Peripheral events, one-cycle pulses except the serial levels
    typedef struct packed {
        logic       sync_serial_done;
        logic       timer_a_ovf;
        logic       async_ctr_ovf;
        logic       timer_c_ovf;
        logic       timer_c_udf;
        logic       timer_fl_cmp;
        logic       timer_fl_ovf;
        logic       timer_fh_cmp;
        logic       timer_fh_ovf;
        logic       timer_g_cap;
        logic       timer_g_ovf;
        logic       adc_done;
        logic [5:0] serial1_req;
        logic [5:0] serial2_req;
    } periph_events_t;

    // Request handed to the core
    typedef struct packed {
        logic        pending;
        logic [4:0]  vector;
        logic [15:0] address;
    } core_request_t;

endpackage

// ==== dv/vic_properties.sv ====
// Port assertions for the interrupt controller
`timescale 1ns/100ps
module vic_checker
    import vic_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          rst_n,
    input wire logic [15:0]   avs_address,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic [31:0]   avs_readdata,
    input wire logic          avs_waitrequest,
    input wire logic          condition_code_mask,
    input wire logic          instr_boundary,
    input wire core_request_t core_request,
    input wire logic          exception_start,
    input wire logic          conversion_trigger_edge
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Register bus
    wait_once_a: assert property ($rose(avs_read | avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("access wait not one cycle");
    read_upper_a: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
    edge_fixed_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == REQ_EDGE_IDX |-> avs_readdata[7:5] == 3'h7)
        else $error("edge select top bits not one");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without read");
    // ==========================================================
    // Core request, exception start and trigger edge
    vec_addr_a: assert property (core_request.pending |->
        core_request.address == {10'h0, core_request.vector, 1'b0})
        else $error("vector address not twice vector");
    reserved_vec_a: assert property (core_request.pending |->
        !VEC_RESERVED[core_request.vector]) else $error("reserved vector dispatched");
    mask_block_a: assert property (condition_code_mask ##1 condition_code_mask |->
        !core_request.pending) else $error("request while masked");
    start_gate_a: assert property (exception_start |->
        $past(instr_boundary) || $past(instr_boundary, 2)) else $error("start off boundary");
    trig_pulse_a: assert property (conversion_trigger_edge |=>
        !conversion_trigger_edge) else $error("trigger edge longer than one cycle");
    cover property (exception_start);
    cover property (core_request.pending && core_request.vector == VEC_TIMER_C);
    cover property (condition_code_mask && !core_request.pending);
endmodule
bind vectored_interrupt_controller vic_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .condition_code_mask(condition_code_mask), .instr_boundary(instr_boundary),
    .core_request(core_request), .exception_start(exception_start),
    .conversion_trigger_edge(conversion_trigger_edge));

// ==== dv/core_model.sv ====
// Processor core model pacing instruction boundaries
`timescale 1ns/100ps
module core_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      instr_boundary
);
    logic [1:0] step_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= 2'h0;
        end else begin
            step_q <= step_q + 2'h1;
        end
    end
    assign instr_boundary = !slow || (step_q == 2'h3);
endmodule

// ==== dv/vectored_interrupt_controller_tb.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module vectored_interrupt_controller_tb import vic_pkg::*;;
    logic           ref_clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [15:0]    avs_address = 16'h0;
    logic           avs_read = 1'b0;
    logic           avs_write = 1'b0;
    logic [31:0]    avs_writedata = 32'h0;
    logic [3:0]     avs_byteenable = 4'h0;
    logic [31:0]    avs_readdata;
    logic           avs_waitrequest;
    logic [4:0]     ext_request_pin = 5'h1f;
    logic [7:0]     wake_pin = 8'h00;
    logic           conversion_trigger_pin = 1'b1;
    logic           timer_c_event_pin = 1'b1;
    logic           timer_f_event_pin = 1'b1;
    periph_events_t periph_events = '0;
    logic           sleep_direct_event = 1'b0;
    logic           condition_code_mask = 1'b0;
    logic           slow = 1'b0;
    logic           instr_boundary;
    core_request_t  core_request;
    logic           exception_start;
    logic           conversion_trigger_edge;
    logic [1:0]     timer_edges;
    logic [31:0]    rd_q;
    int             errors = 0;
    int             n_checks = 0;
    int             cyc = 0;
    int             starts = 0;
    int             trig = 0;
    int             s0;
    logic [15:0]    ra [7] = '{WAKE_EDGE_IDX, REQ_EDGE_IDX, ENABLE_1_IDX, ENABLE_2_IDX,
                               FLAGS_1_IDX, FLAGS_2_IDX, WAKE_FLAGS_IDX};
    logic [7:0]     rv [7] = '{8'h00, 8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    int             eb [10] = '{21, 20, 19, 18, 17, 16, 15, 14, 13, 12};
    int             fb [10] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 6};
    logic [4:0]     vb [10] = '{VEC_ASYNC, VEC_TIMER_C, VEC_TIMER_C, VEC_FL, VEC_FL,
                                VEC_FH, VEC_FH, VEC_G, VEC_G, VEC_ADC};

    always #12.5 ref_clk = ~ref_clk;

    vectored_interrupt_controller DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_request_pin(ext_request_pin), .wake_pin(wake_pin),
        .conversion_trigger_pin(conversion_trigger_pin), .timer_c_event_pin(timer_c_event_pin),
        .timer_f_event_pin(timer_f_event_pin), .periph_events(periph_events),
        .sleep_direct_event(sleep_direct_event), .condition_code_mask(condition_code_mask),
        .instr_boundary(instr_boundary), .core_request(core_request),
        .exception_start(exception_start), .conversion_trigger_edge(conversion_trigger_edge),
        .timer_c_edge(timer_edges[0]), .timer_f_edge(timer_edges[1]));

    core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
        .instr_boundary(instr_boundary));

    // ==========================================================
    // Shared tasks
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= 4'h1;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        rd_q = avs_readdata;
        chk("bus answer", 32'h0, {31'h0, n >= 20});
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, rd_q);
    endtask
    task automatic reqchk(input logic [4:0] v, input string nm);
        chk(nm, {10'h0, 1'b1, v, 10'h0, v, 1'b0}, 32'(core_request));
    endtask
    task automatic pulse(input logic [23:0] m);
        periph_events <= periph_events_t'(m);
        @(posedge ref_clk);
        periph_events <= '0;
        repeat (4) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (exception_start === 1'b1) starts++;
        trig += $countones({conversion_trigger_edge, timer_edges});
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i], "reset value");
        bus(1'b1, 16'h0100, 8'hff);
        rd(16'h0100, 8'h00, "unmapped");
        bus(1'b1, REQ_EDGE_IDX, 8'h00);
        rd(REQ_EDGE_IDX, 8'he0, "edge fixed ones");
        bus(1'b1, REQ_EDGE_IDX, 8'h1f);
        rd(REQ_EDGE_IDX, 8'hff, "edge bits");
        bus(1'b1, FLAGS_1_IDX, 8'hff);
        rd(FLAGS_1_IDX, 8'h20, "flag write one");
        bus(1'b1, FLAGS_1_IDX, 8'h00);
        rd(FLAGS_1_IDX, 8'h00, "flag write zero");
        $display("test registers done");
        bus(1'b1, ENABLE_2_IDX, 8'hdf);
        for (int i = 0; i < 10; i++) begin
            pulse(24'h1 << eb[i]);
            reqchk(vb[i], "shared vector");
            rd(FLAGS_2_IDX, 8'h1 << fb[i], "periph flag");
            bus(1'b1, FLAGS_2_IDX, 8'h00);
        end
        sleep_direct_event <= 1'b1;
        pulse(24'h0);
        sleep_direct_event <= 1'b0;
        reqchk(VEC_DIRECT, "direct vector");
        bus(1'b1, FLAGS_2_IDX, 8'h00);
        pulse((24'h1 << 12) | (24'h1 << 16));
        reqchk(VEC_FH, "priority");
        bus(1'b1, FLAGS_2_IDX, 8'h00);
        for (int j = 0; j < 6; j++) begin
            periph_events.serial2_req <= 6'h1 << j;
            repeat (4) @(posedge ref_clk);
            reqchk(VEC_SER2, "serial two");
            periph_events.serial1_req <= 6'h1 << j;
            repeat (4) @(posedge ref_clk);
            reqchk(VEC_SER1, "serial priority");
            periph_events <= '0;
            repeat (4) @(posedge ref_clk);
        end
        $display("test vectors done");
        condition_code_mask <= 1'b1;
        pulse(24'h1 << 20);
        chk("masked", 32'h0, {31'h0, core_request.pending});
        rd(FLAGS_2_IDX, 8'h02, "masked flag");
        condition_code_mask <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reqchk(VEC_TIMER_C, "unmasked");
        bus(1'b1, ENABLE_2_IDX, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("disabled", 32'h0, {31'h0, core_request.pending});
        s0 = starts;
        slow <= 1'b1;
        bus(1'b1, ENABLE_2_IDX, 8'hdf);
        repeat (8) @(posedge ref_clk);
        chk("exception start", 32'h1, {31'h0, starts > s0});
        slow <= 1'b0;
        bus(1'b1, FLAGS_2_IDX, 8'h00);
        $display("test mask done");
        bus(1'b1, REQ_EDGE_IDX, 8'h00);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ENABLE_1_IDX, 8'h1 << i);
            ext_request_pin[i] <= 1'b0;
            repeat (5) @(posedge ref_clk);
            reqchk(VEC_PIN0 + 5'(i), "pin falling");
            bus(1'b1, FLAGS_1_IDX, 8'h00);
            bus(1'b1, ENABLE_1_IDX, 8'h00);
            bus(1'b1, REQ_EDGE_IDX, 8'h1 << i);
            ext_request_pin[i] <= 1'b1;
            repeat (5) @(posedge ref_clk);
            chk("pin gated", 32'h0, {31'h0, core_request.pending});
            rd(FLAGS_1_IDX, 8'h1 << i, "pin rising");
            bus(1'b1, FLAGS_1_IDX, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            {conversion_trigger_pin, timer_c_event_pin, timer_f_event_pin} <= 3'h0;
            repeat (5) @(posedge ref_clk);
            {conversion_trigger_pin, timer_c_event_pin, timer_f_event_pin} <= 3'h7;
            repeat (5) @(posedge ref_clk);
            chk("trigger edges", 3 * k + 3, trig);
            bus(1'b1, REQ_EDGE_IDX, 8'h00);
        end
        $display("test pins done");
        bus(1'b1, ENABLE_1_IDX, 8'h20);
        for (int i = 0; i < 8; i++) begin
            wake_pin[i] <= 1'b1;
            repeat (5) @(posedge ref_clk);
            wake_pin[i] <= 1'b0;
            repeat (5) @(posedge ref_clk);
            reqchk(VEC_WAKE, "wake vector");
            rd(WAKE_FLAGS_IDX, 8'h1 << i, "wake flag");
            bus(1'b1, WAKE_FLAGS_IDX, 8'h00);
            bus(1'b1, FLAGS_1_IDX, 8'h00);
        end
        $display("test wake done");
        complete_run();
    end
endmodule
